/* rtc_core_model.sv */
// Behavioural model of the timekeeping core register file
`timescale 1ns/100ps
module rtc_core_model
(
	input wire logic clk_sys,
	input wire logic [3:0] core_addr,
	input wire logic [7:0] core_wdata,
	input wire logic core_rd_strobe,
	input wire logic core_wr_strobe,
	output logic [7:0] core_rdata
);
	logic [7:0] mem [16];
	logic [7:0] junk = 8'h5A;
	// Moving pattern outside reads, so stale data never passes as a match
	assign core_rdata = core_rd_strobe ? mem[core_addr] : junk;
	always @(posedge clk_sys)
	begin
		junk <= junk + 8'h3B;
		if (core_wr_strobe)
			mem[core_addr] <= core_wdata;
	end
endmodule

/* rtc_indirect_access_lock.sv */
// Lock-protected indirect access port to the timekeeping core registers
`timescale 1ns/100ps
module rtc_indirect_access_lock
	import rtc_lock_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic [3:0] core_addr,
	output logic [7:0] core_wdata,
	output logic core_rd_strobe,
	output logic core_wr_strobe,
	input wire logic [7:0] core_rdata,
	input wire logic [1:0] timebase_sel,
	input wire logic timebase_ext_pin,
	input wire logic timebase_slow_osc,
	input wire logic timebase_osc,
	input wire logic timebase_as_sysclk,
	input wire logic timebase_route_en,
	input wire logic sleep_mode,
	input wire logic sleep_route_capable,
	output logic timebase_level,
	output logic timebase_sysclk_sel,
	output logic timebase_pin
);

	// Core register windows that step the select after a transfer
	function automatic logic is_multibyte(input logic [3:0] a);
		is_multibyte = (a >= CAPTURE_FIRST && a <= CAPTURE_LAST) ||
			(a >= ALARM_FIRST && a <= ALARM_LAST);
	endfunction

	lock_state_t lock_r, lock_nxt;
	xfer_state_t xfer_r, xfer_nxt;
	logic read_ahead_r, read_ahead_nxt;
	logic short_r, short_nxt;
	logic [3:0] sel_r, sel_nxt;
	logic [7:0] data_r, data_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic busy;
	logic wr_key, wr_ctrl, wr_data, rd_data, open;
	logic [2:0] len;

	assign busy = (xfer_r != XFER_IDLE);
	assign open = (lock_r == LOCK_OPEN);
	assign wr_key = sfr_wr && sfr_addr == KEY_OFS;
	assign wr_ctrl = sfr_wr && sfr_addr == ADDR_CTRL_OFS;
	assign wr_data = sfr_wr && sfr_addr == DATA_OFS;
	assign rd_data = sfr_rd && sfr_addr == DATA_OFS;
	// Length sampled per transfer from the current strobe option
	assign len = short_r ? ACCESS_CYCLES_SHORT : ACCESS_CYCLES_NORMAL;

	// Key sequencer
	always_comb
	begin
		lock_nxt = lock_r;
		if (wr_key)
		begin
			case (lock_r)
				LOCK_LOCKED:
					if (sfr_wdata == KEY_FIRST)
						lock_nxt = LOCK_FIRST_KEY;
				LOCK_FIRST_KEY:
					if (sfr_wdata == KEY_SECOND)
						lock_nxt = LOCK_OPEN;
					else
						lock_nxt = LOCK_DISABLED;
				LOCK_OPEN:
					lock_nxt = LOCK_LOCKED;
				LOCK_DISABLED:
					lock_nxt = LOCK_DISABLED;
				default:
					lock_nxt = LOCK_DISABLED;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			lock_r <= LOCK_LOCKED;
		end
		else
		begin
			lock_r <= lock_nxt;
		end
	end

	// Transfer sequencer and the control fields it owns
	always_comb
	begin
		xfer_nxt = xfer_r;
		read_ahead_nxt = read_ahead_r;
		short_nxt = short_r;
		sel_nxt = sel_r;
		data_nxt = data_r;
		cnt_nxt = cnt_r;

		case (xfer_r)
			XFER_IDLE:
			begin
				// Accesses while busy are dropped so a running strobe never
				// sees its address or data change underneath it
				if (open && wr_ctrl)
				begin
					read_ahead_nxt = sfr_wdata[READ_AHEAD_BIT];
					short_nxt = sfr_wdata[SHORT_BIT];
					sel_nxt = sfr_wdata[SEL_MSB:SEL_LSB];
					if (sfr_wdata[BUSY_BIT])
					begin
						xfer_nxt = XFER_READ;
						cnt_nxt = sfr_wdata[SHORT_BIT] ?
							ACCESS_CYCLES_SHORT : ACCESS_CYCLES_NORMAL;
					end
				end
				else if (open && wr_data)
				begin
					data_nxt = sfr_wdata;
					xfer_nxt = XFER_WRITE;
					cnt_nxt = len;
				end
				else if (open && rd_data && read_ahead_r)
				begin
					xfer_nxt = XFER_READ;
					cnt_nxt = len;
				end
			end
			XFER_READ, XFER_WRITE:
			begin
				cnt_nxt = cnt_r - 3'd1;
				if (cnt_r == 3'd1)
				begin
					if (xfer_r == XFER_READ)
						data_nxt = core_rdata;
					if (is_multibyte(sel_r))
						sel_nxt = sel_r + 4'd1;
					xfer_nxt = XFER_IDLE;
				end
			end
			default:
				xfer_nxt = XFER_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			xfer_r <= XFER_IDLE;
			read_ahead_r <= CTRL_RESET[READ_AHEAD_BIT];
			short_r <= CTRL_RESET[SHORT_BIT];
			sel_r <= CTRL_RESET[SEL_MSB:SEL_LSB];
			data_r <= DATA_RESET;
			cnt_r <= 3'd0;
		end
		else
		begin
			xfer_r <= xfer_nxt;
			read_ahead_r <= read_ahead_nxt;
			short_r <= short_nxt;
			sel_r <= sel_nxt;
			data_r <= data_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Read-back register: holds until the next processor read
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (sfr_rd)
		begin
			case (sfr_addr)
				KEY_OFS:
					rdata_nxt = lock_r;
				ADDR_CTRL_OFS:
					rdata_nxt = {busy, read_ahead_r, 1'b0, short_r,
						sel_r};
				DATA_OFS:
					rdata_nxt = data_r;
				default:
					rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_r <= 8'h00;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign sfr_rdata = rdata_r;
	assign core_addr = sel_r;
	assign core_wdata = data_r;
	// Strobe held for the whole transfer so the core, on its own timebase,
	// has the full window to resolve it; core_rdata must be steady by the end
	assign core_rd_strobe = (xfer_r == XFER_READ);
	assign core_wr_strobe = (xfer_r == XFER_WRITE);

	// Timebase sources are foreign clocks: two flops before any use
	logic [2:0] tb_meta_r, tb_sync_r;
	logic [2:0] tb_meta_nxt, tb_sync_nxt;
	logic tb_level_r, tb_level_nxt;
	logic sysclk_sel_r, sysclk_sel_nxt;
	logic pin_r, pin_nxt;

	always_comb
	begin
		tb_meta_nxt = {timebase_osc, timebase_slow_osc, timebase_ext_pin};
		tb_sync_nxt = tb_meta_r;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tb_meta_r <= 3'b000;
			tb_sync_r <= 3'b000;
		end
		else
		begin
			tb_meta_r <= tb_meta_nxt;
			tb_sync_r <= tb_sync_nxt;
		end
	end

	always_comb
	begin
		case (timebase_sel)
			TB_EXTERNAL:
				tb_level_nxt = tb_sync_r[0];
			TB_SLOW_OSC:
				tb_level_nxt = tb_sync_r[1];
			TB_OSCILLATOR:
				tb_level_nxt = tb_sync_r[2];
			default:
				tb_level_nxt = 1'b0;
		endcase
		sysclk_sel_nxt = timebase_as_sysclk;
		// Pin routing survives deep sleep only on capable variants
		pin_nxt = tb_level_r && timebase_route_en &&
			(!sleep_mode || sleep_route_capable);
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			tb_level_r <= 1'b0;
			sysclk_sel_r <= 1'b0;
			pin_r <= 1'b0;
		end
		else
		begin
			tb_level_r <= tb_level_nxt;
			sysclk_sel_r <= sysclk_sel_nxt;
			pin_r <= pin_nxt;
		end
	end

	assign timebase_level = tb_level_r;
	assign timebase_sysclk_sel = sysclk_sel_r;
	assign timebase_pin = pin_r;

endmodule

/* rtc_lock_assertions.sv */
// Checker for the indirect access port
`timescale 1ns/100ps
module rtc_lock_assertions
	import rtc_lock_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic [3:0] core_addr,
	input wire logic [7:0] core_wdata,
	input wire logic core_rd_strobe,
	input wire logic core_wr_strobe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_rlen;
		$rose(core_rd_strobe) |-> core_rd_strobe[*6] ##[1:2] !core_rd_strobe;
	endproperty
	a_rlen: assert property (p_rlen) else $error("read length");
	property p_wlen;
		$rose(core_wr_strobe) |-> core_wr_strobe[*6] ##[1:2] !core_wr_strobe;
	endproperty
	a_wlen: assert property (p_wlen) else $error("write length");
	property p_wcause;
		$rose(core_wr_strobe) |-> $past(sfr_wr) && $past(sfr_addr) == DATA_OFS;
	endproperty
	a_wcause: assert property (p_wcause) else $error("write cause");
	property p_rcause;
		$rose(core_rd_strobe) |-> $past(sfr_wr) || $past(sfr_rd);
	endproperty
	a_rcause: assert property (p_rcause) else $error("read cause");
	property p_unused;
		sfr_rd && sfr_addr == ADDR_CTRL_OFS |=> !sfr_rdata[UNUSED_BIT];
	endproperty
	a_unused: assert property (p_unused) else $error("bit 5 set");
	property p_busy;
		sfr_rd && sfr_addr == ADDR_CTRL_OFS && core_rd_strobe
		|=> sfr_rdata[BUSY_BIT];
	endproperty
	a_busy: assert property (p_busy) else $error("busy low");
	property p_key;
		sfr_rd && sfr_addr == KEY_OFS |=> sfr_rdata[7:2] == 6'h00;
	endproperty
	a_key: assert property (p_key) else $error("bad state");
	property p_addr;
		core_rd_strobe && $past(core_rd_strobe) |-> $stable(core_addr);
	endproperty
	a_addr: assert property (p_addr) else $error("select moved");
	property p_wdat;
		core_wr_strobe && $past(core_wr_strobe) |-> $stable(core_wdata);
	endproperty
	a_wdat: assert property (p_wdat) else $error("data moved");
endmodule
bind rtc_indirect_access_lock rtc_lock_assertions chk (.clk_sys(clk_sys),
	.resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .core_addr(core_addr), .core_wdata(core_wdata),
	.core_rd_strobe(core_rd_strobe), .core_wr_strobe(core_wr_strobe));

/* rtc_lock_pkg.sv */
// Constants shared by the indirect timekeeping access port
package rtc_lock_pkg;

	// Processor-side register addresses
	localparam logic [7:0] ADDR_CTRL_OFS = 8'hAC;
	localparam logic [7:0] DATA_OFS = 8'hAD;
	localparam logic [7:0] KEY_OFS = 8'hAE;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;

	// Address/control field positions
	localparam int BUSY_BIT = 7;
	localparam int READ_AHEAD_BIT = 6;
	localparam int UNUSED_BIT = 5;
	localparam int SHORT_BIT = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 0;

	// Key codes
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;

	// Interface lock states as read back from the key/status register
	typedef enum logic [7:0] {
		LOCK_LOCKED = 8'h00,
		LOCK_FIRST_KEY = 8'h01,
		LOCK_OPEN = 8'h02,
		LOCK_DISABLED = 8'h03
	} lock_state_t;

	// Internal register windows that auto-increment
	localparam logic [3:0] CAPTURE_FIRST = 4'h0;
	localparam logic [3:0] CAPTURE_LAST = 4'h3;
	localparam logic [3:0] ALARM_FIRST = 4'h8;
	localparam logic [3:0] ALARM_LAST = 4'hB;

	// Indirect access length in system clock cycles
	localparam logic [2:0] ACCESS_CYCLES_NORMAL = 3'd7;
	localparam logic [2:0] ACCESS_CYCLES_SHORT = 3'd6;

	// Timebase source frequencies in Hz (informational)
	localparam int XTAL_FREQ_HZ = 32768;
	localparam int SELF_OSC_MIN_HZ = 10000;
	localparam int SELF_OSC_MAX_HZ = 40000;
	localparam int SLOW_OSC_NOM_HZ = 16400;

	// Timebase source selection
	typedef enum logic [1:0] {
		TB_EXTERNAL = 2'b00,
		TB_SLOW_OSC = 2'b01,
		TB_OSCILLATOR = 2'b10
	} timebase_src_t;

	// Indirect transfer sequencer
	typedef enum logic [1:0] {
		XFER_IDLE = 2'b00,
		XFER_READ = 2'b01,
		XFER_WRITE = 2'b10
	} xfer_state_t;

endpackage

/* tb.sv */
// Self-checking bench for the indirect access port
`timescale 1ns/100ps
module tb
	import rtc_lock_pkg::*;
;
	logic clk_sys, resetn, sfr_wr, sfr_rd, core_rd_strobe, core_wr_strobe;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, core_wdata, core_rdata, v, e;
	logic [3:0] core_addr;
	logic [1:0] sel;
	logic ext, slow, osc, as, route, slp, cap, lvl, sys, pin;
	int failures, total_checks, n;
	rtc_indirect_access_lock uut (.clk_sys(clk_sys), .resetn(resetn),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_rd_strobe(core_rd_strobe),
		.core_wr_strobe(core_wr_strobe), .core_rdata(core_rdata),
		.timebase_sel(sel), .timebase_ext_pin(ext), .timebase_slow_osc(slow),
		.timebase_osc(osc), .timebase_as_sysclk(as), .timebase_route_en(route),
		.sleep_mode(slp), .sleep_route_capable(cap), .timebase_level(lvl),
		.timebase_sysclk_sel(sys), .timebase_pin(pin));
	rtc_core_model core_m (.clk_sys(clk_sys), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_rd_strobe(core_rd_strobe),
		.core_wr_strobe(core_wr_strobe), .core_rdata(core_rdata));
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	function logic exp_lvl(input logic [1:0] s);
		return s == 2'd0 ? ext : s == 2'd1 ? slow : s == 2'd2 ? osc : 1'b0;
	endfunction
	task chk(input logic [7:0] g, input logic [7:0] x);
		total_checks++;
		if (g !== x)
		begin
			$display("[ERR] %0t got %h exp %h", $time, g, x);
			failures++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1 v = sfr_rdata;
	endtask
	// Bounded window; a stuck strobe shows up as a wrong count
	task cnt;
		n = 0;
		repeat (10)
		begin
			@(negedge clk_sys);
			if (core_rd_strobe === 1'b1 || core_wr_strobe === 1'b1)
				n++;
		end
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		resetn = 1'b0;
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h0_0000;
		{sel, ext, slow, osc, as, route, slp, cap} = 9'h000;
		failures = 0;
		total_checks = 0;
		void'($urandom(60069));
		for (int i = 0; i < 16; i++)
			core_m.mem[i] = 8'($urandom);
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(KEY_OFS);
		chk(v, LOCK_LOCKED);
		rd(DATA_OFS);
		chk(v, DATA_RESET);
		rd(8'hAB);
		chk(v, 8'h00);
		wr(ADDR_CTRL_OFS, 8'h85);
		cnt;
		chk(8'(n), 8'h00);
		rd(ADDR_CTRL_OFS);
		chk(v, CTRL_RESET);
		wr(KEY_OFS, 8'h5A);
		rd(KEY_OFS);
		chk(v, LOCK_LOCKED);
		wr(KEY_OFS, KEY_FIRST);
		rd(KEY_OFS);
		chk(v, LOCK_FIRST_KEY);
		wr(KEY_OFS, KEY_SECOND);
		rd(KEY_OFS);
		chk(v, LOCK_OPEN);
		wr(ADDR_CTRL_OFS, 8'h60);
		rd(ADDR_CTRL_OFS);
		chk(v, 8'h40);
		wr(ADDR_CTRL_OFS, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			e = 8'($urandom);
			wr(DATA_OFS, e);
			cnt;
			chk(8'(n), 8'h07);
			chk(core_m.mem[i], e);
		end
		rd(ADDR_CTRL_OFS);
		chk(v, 8'h04);
		wr(ADDR_CTRL_OFS, 8'h1C);
		e = 8'($urandom);
		wr(DATA_OFS, e);
		cnt;
		chk(8'(n), 8'h06);
		chk(core_m.mem[12], e);
		rd(ADDR_CTRL_OFS);
		chk(v, 8'h1C);
		for (int i = 0; i < 2; i++)
		begin
			wr(ADDR_CTRL_OFS, 8'h88 + 8'(17 * i));
			cnt;
			chk(8'(n), 8'(7 - i));
			rd(DATA_OFS);
			chk(v, core_m.mem[8 + i]);
			rd(ADDR_CTRL_OFS);
			chk(v, 8'h09 + 8'(17 * i));
		end
		wr(ADDR_CTRL_OFS, 8'h85);
		rd(ADDR_CTRL_OFS);
		chk(v, 8'h85);
		cnt;
		rd(ADDR_CTRL_OFS);
		chk(v, 8'h05);
		wr(ADDR_CTRL_OFS, 8'hCA);
		cnt;
		for (int i = 0; i < 2; i++)
		begin
			rd(DATA_OFS);
			chk(v, core_m.mem[10 + i]);
			cnt;
			chk(8'(n), 8'h07);
		end
		wr(KEY_OFS, 8'($urandom));
		rd(KEY_OFS);
		chk(v, LOCK_LOCKED);
		wr(KEY_OFS, KEY_FIRST);
		wr(KEY_OFS, KEY_FIRST);
		rd(KEY_OFS);
		chk(v, LOCK_DISABLED);
		wr(KEY_OFS, KEY_FIRST);
		wr(KEY_OFS, KEY_SECOND);
		rd(KEY_OFS);
		chk(v, LOCK_DISABLED);
		wr(DATA_OFS, 8'h11);
		cnt;
		chk(8'(n), 8'h00);
		// Only a system reset may leave the disabled state
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(KEY_OFS);
		chk(v, LOCK_LOCKED);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			sel <= 2'(i);
			{ext, slow, osc, as, route, slp, cap} <= 7'($urandom);
			repeat (6) @(posedge clk_sys);
			#1 e = {5'h00, exp_lvl(sel), as, exp_lvl(sel) & route & (!slp | cap)};
			chk({5'h00, lvl, sys, pin}, e);
		end
		end_of_test;
	end
endmodule
